// file: adcr_consts.vh
/*
 Register offsets, field positions, reset values and timing figures of the
 converter result, gain, clock and trim register set.
 Assumes nothing; definitions only.
*/
`ifndef ADCR_CONSTS_VH
`define ADCR_CONSTS_VH

`define ADCR_ADDR_RESULT_FIRST  4'h1
`define ADCR_ADDR_RESULT_SECOND 4'h2
`define ADCR_ADDR_AMP_CONFIG    4'h3
`define ADCR_ADDR_CLOCK_CONFIG  4'h4
`define ADCR_ADDR_TRIM_CONFIG   4'h5

`define ADCR_AMP_RESET          8'h00
`define ADCR_CLOCK_RESET        8'h03
`define ADCR_TRIM_RESET         8'h00

`define ADCR_AMP_MASK           8'h3F
`define ADCR_CLOCK_MASK         8'h37
`define ADCR_TRIM_MASK          8'h3F

`define ADCR_SECOND_GAIN_HI     5
`define ADCR_SECOND_GAIN_LO     4
`define ADCR_FIRST_EN_BIT       3
`define ADCR_FIRST_GAIN_HI      2
`define ADCR_FIRST_GAIN_LO      0
`define ADCR_DIVIDER_HI         5
`define ADCR_DIVIDER_LO         4
`define ADCR_OSR_HI             2
`define ADCR_OSR_LO             0
`define ADCR_TRIM_EN_BIT        5
`define ADCR_TRIM_CODE_HI       4
`define ADCR_TRIM_CODE_LO       0

`define ADCR_MODE_IDLE          4'h0
`define ADCR_MODE_SINGLE        4'h2
`define ADCR_MODE_CONT          4'h3
`define ADCR_MODE_CHOPPED_CONVERSION_SINGLE   4'h4
`define ADCR_MODE_CHOPPED_CONVERSION_CONT     4'h5

`define ADCR_OSR_BASE           12'd64
`define ADCR_MULT_SINGLE        3'd3
`define ADCR_MULT_CONT          3'd1
`define ADCR_MULT_CHOPPED_CONVERSION_SINGLE   3'd6
`define ADCR_MULT_CHOPPED_CONVERSION_CONT     3'd3

`define ADCR_RESULT_MAX         16'h7FFF
`define ADCR_RESULT_MIN         16'h8000

`endif

// file: adcr_conv_timer.v
/*
 Conversion timer: modulator clock enable from the oscillator clock and the
 conversion-done pulse after the oversampling count, per conversion mode.
 Assumes sys_clk is the oscillator clock and mode/start come from same domain.
*/
`timescale 1ns/1ps
`include "adcr_consts.vh"

module adcr_conv_timer (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire        start,
   input  wire [3:0]  mode,
   input  wire [1:0]  divider,
   input  wire [1:0]  osr_code,
   output reg         mod_tick,
   output reg         done,
   output reg         busy
);
   reg  [3:0]  div_cnt_reg;
   reg  [11:0] tick_cnt_reg;
   reg  [2:0]  mult;
   wire [3:0]  div_last;
   wire [11:0] osr_val;
   wire [14:0] tick_limit;
   wire        cont_mode;
   wire        single_mode;

   assign div_last    = (4'h2 << divider) - 4'h1;
   assign osr_val     = `ADCR_OSR_BASE << osr_code;
   assign tick_limit  = osr_val * mult;
   assign cont_mode   = (mode == `ADCR_MODE_CONT) || (mode == `ADCR_MODE_CHOPPED_CONVERSION_CONT);
   assign single_mode = (mode == `ADCR_MODE_SINGLE) || (mode == `ADCR_MODE_CHOPPED_CONVERSION_SINGLE);

   // Conversion length in modulator ticks per mode
   always @* begin
      case (mode)
         `ADCR_MODE_SINGLE:      mult = `ADCR_MULT_SINGLE;
         `ADCR_MODE_CONT:        mult = `ADCR_MULT_CONT;
         `ADCR_MODE_CHOPPED_CONVERSION_SINGLE: mult = `ADCR_MULT_CHOPPED_CONVERSION_SINGLE;
         `ADCR_MODE_CHOPPED_CONVERSION_CONT:   mult = `ADCR_MULT_CHOPPED_CONVERSION_CONT;
         default:                mult = `ADCR_MULT_SINGLE;
      endcase
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         div_cnt_reg  <= 4'h0;
         tick_cnt_reg <= 12'h000;
         mod_tick     <= 1'b0;
         done         <= 1'b0;
         busy         <= 1'b0;
      end else begin
         done     <= 1'b0;
         mod_tick <= 1'b0;
         // Modulator clock divider
         if (div_cnt_reg >= div_last) begin
            div_cnt_reg <= 4'h0;
            mod_tick    <= 1'b1;
         end else begin
            div_cnt_reg <= div_cnt_reg + 4'h1;
         end
         if (!busy) begin
            tick_cnt_reg <= 12'h000;
            busy         <= cont_mode || (single_mode && start);
         end else if (!(cont_mode || single_mode)) begin
            busy <= 1'b0;
         end else if (div_cnt_reg >= div_last) begin
            // Oversampling count ends a conversion
            if ({3'b000, tick_cnt_reg} >= tick_limit - 15'd1) begin
               tick_cnt_reg <= 12'h000;
               done         <= 1'b1;
               busy         <= cont_mode;
            end else begin
               tick_cnt_reg <= tick_cnt_reg + 12'h001;
            end
         end
      end
   end
endmodule

// file: adcr_regs.v
/*
 Result, amplifier gain, converter clock and offset-trim register set with
 result scaling and two-byte read coherence.
 Assumes a serial front end turns host frames into the register port strobes,
 and filt_data is the unity-gain filter output from the analog domain.
*/
// What this block does
// - Each finished conversion loads result registers, unreset
// - Result is 16-bit two's complement, saturating
// - Result scales input by both stage gains
// - Second-stage gain x1, x2, x4; code 3 reserved
// - Amp config bit 3 enables first stage
// - First-stage gain is two to the code
// - Modulator clock is oscillator over 2..16
// - Oversampling ratio 64 to 512; codes 4-7 reserved
// - Single rate is osc/osr/2^(div+1)/3
// - Trim register bit 5 powers trim DAC
// - Trim code is signed five-bit, MSB sign
// - Trim voltage adds or subtracts at first stage
// - Chopped single runs half rate, no offset coefficient
// - Chopped continuous runs third rate, no offset coefficient
`timescale 1ns/1ps
`include "adcr_consts.vh"

module adcr_regs #(
   parameter TRIM_STEP = 16
) (
   input  wire        sys_clk,
   input  wire        rst,
   input  wire [3:0]  reg_addr,
   input  wire        reg_wr,
   input  wire        reg_rd,
   input  wire [7:0]  reg_wdata,
   output reg  [7:0]  reg_rdata,
   output reg         reg_rvalid,
   input  wire [3:0]  conv_mode,
   input  wire        conv_start,
   input  wire [15:0] filt_data,
   output reg         first_stage_enable,
   output reg  [2:0]  first_stage_gain,
   output reg  [1:0]  second_stage_gain,
   output reg         trim_dac_enable,
   output reg  [4:0]  trim_dac_code,
   output reg         offset_apply,
   output reg         mod_clk_en,
   output reg         conv_done,
   output reg         conv_busy
);
   reg  [7:0]  amp_config_reg;
   reg  [7:0]  clock_config_reg;
   reg  [7:0]  trim_config_reg;
   reg  [15:0] conversion_result_reg;
   reg  [7:0]  second_hold_reg;
   reg  [15:0] filt_meta_reg;
   reg  [15:0] filt_sync_reg;
   reg  [15:0] filt_prev_reg;
   reg  [15:0] filt_word_reg;
   reg  [7:0]  rdata_next;
   reg  [25:0] scaled;
   reg  [15:0] result_next;
   wire        tick;
   wire        done;
   wire        busy;
   wire [22:0] first_out;
   reg  [31:0] trim_prod;
   reg  [23:0] trim_mag;
   reg  signed [23:0] trim_volts;
   wire signed [23:0] trimmed;
   wire [2:0]  g1_shift;

   adcr_conv_timer u_timer (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .start    (conv_start),
      .mode     (conv_mode),
      .divider  (clock_config_reg[`ADCR_DIVIDER_HI:`ADCR_DIVIDER_LO]),
      .osr_code (clock_config_reg[`ADCR_OSR_HI-1:`ADCR_OSR_LO]),
      .mod_tick (tick),
      .done     (done),
      .busy     (busy)
   );

   // Analog-domain data passes two flip-flops, then is taken only when steady
   always @(posedge sys_clk) begin
      filt_meta_reg <= filt_data;
      filt_sync_reg <= filt_meta_reg;
      filt_prev_reg <= filt_sync_reg;
      if (filt_sync_reg == filt_prev_reg)
         filt_word_reg <= filt_sync_reg;
   end

   // First stage: bypassed at unity when disabled
   assign g1_shift  = amp_config_reg[`ADCR_FIRST_EN_BIT] ?
                      amp_config_reg[`ADCR_FIRST_GAIN_HI:`ADCR_FIRST_GAIN_LO] : 3'd0;
   assign first_out = {{7{filt_word_reg[15]}}, filt_word_reg} << g1_shift;

   // Trim DAC adds or subtracts its magnitude at the first stage output
   always @* begin
      trim_prod = {28'h0000000, trim_config_reg[`ADCR_TRIM_CODE_HI-1:`ADCR_TRIM_CODE_LO]}
                  * TRIM_STEP;
      trim_mag  = trim_prod[23:0];
      if (!trim_config_reg[`ADCR_TRIM_EN_BIT])
         trim_volts = 24'sd0;
      else if (trim_config_reg[`ADCR_TRIM_CODE_HI])
         trim_volts = -$signed(trim_mag);
      else
         trim_volts = $signed(trim_mag);
   end
   assign trimmed = $signed({first_out[22], first_out}) + trim_volts;

   // Second stage gain, then saturate into the 16-bit code range
   always @* begin
      case (amp_config_reg[`ADCR_SECOND_GAIN_HI:`ADCR_SECOND_GAIN_LO])
         2'd1:    scaled = {{2{trimmed[23]}}, trimmed} << 1;
         2'd2:    scaled = {{2{trimmed[23]}}, trimmed} << 2;
         default: scaled = {{2{trimmed[23]}}, trimmed};
      endcase
      if (!scaled[25] && (scaled[24:15] != 10'h000))
         result_next = `ADCR_RESULT_MAX;
      else if (scaled[25] && (scaled[24:15] != 10'h3FF))
         result_next = `ADCR_RESULT_MIN;
      else
         result_next = scaled[15:0];
   end

   // Result registers carry no reset value
   always @(posedge sys_clk) begin
      if (done)
         conversion_result_reg <= result_next;
      if (reg_rd && (reg_addr == `ADCR_ADDR_RESULT_FIRST))
         second_hold_reg <= conversion_result_reg[7:0];
   end

   // Configuration registers
   always @(posedge sys_clk) begin
      if (rst) begin
         amp_config_reg   <= `ADCR_AMP_RESET;
         clock_config_reg <= `ADCR_CLOCK_RESET;
         trim_config_reg  <= `ADCR_TRIM_RESET;
      end else if (reg_wr) begin
         case (reg_addr)
            `ADCR_ADDR_AMP_CONFIG:   amp_config_reg   <= reg_wdata & `ADCR_AMP_MASK;
            `ADCR_ADDR_CLOCK_CONFIG: clock_config_reg <= reg_wdata & `ADCR_CLOCK_MASK;
            `ADCR_ADDR_TRIM_CONFIG:  trim_config_reg  <= reg_wdata & `ADCR_TRIM_MASK;
            default: begin
            end
         endcase
      end
   end

   // Read mux
   always @* begin
      case (reg_addr)
         `ADCR_ADDR_RESULT_FIRST:  rdata_next = conversion_result_reg[15:8];
         `ADCR_ADDR_RESULT_SECOND: rdata_next = second_hold_reg;
         `ADCR_ADDR_AMP_CONFIG:    rdata_next = amp_config_reg;
         `ADCR_ADDR_CLOCK_CONFIG:  rdata_next = clock_config_reg;
         `ADCR_ADDR_TRIM_CONFIG:   rdata_next = trim_config_reg;
         default:                  rdata_next = 8'h00;
      endcase
   end

   // Registered outputs
   always @(posedge sys_clk) begin
      if (rst) begin
         reg_rdata          <= 8'h00;
         reg_rvalid         <= 1'b0;
         first_stage_enable <= 1'b0;
         first_stage_gain   <= 3'h0;
         second_stage_gain  <= 2'h0;
         trim_dac_enable    <= 1'b0;
         trim_dac_code      <= 5'h00;
         offset_apply       <= 1'b1;
         mod_clk_en         <= 1'b0;
         conv_done          <= 1'b0;
         conv_busy          <= 1'b0;
      end else begin
         reg_rvalid         <= reg_rd;
         if (reg_rd)
            reg_rdata <= rdata_next;
         first_stage_enable <= amp_config_reg[`ADCR_FIRST_EN_BIT];
         first_stage_gain   <= amp_config_reg[`ADCR_FIRST_GAIN_HI:`ADCR_FIRST_GAIN_LO];
         second_stage_gain  <= amp_config_reg[`ADCR_SECOND_GAIN_HI:`ADCR_SECOND_GAIN_LO];
         trim_dac_enable    <= trim_config_reg[`ADCR_TRIM_EN_BIT];
         trim_dac_code      <= trim_config_reg[`ADCR_TRIM_CODE_HI:`ADCR_TRIM_CODE_LO];
         offset_apply       <= !((conv_mode == `ADCR_MODE_CHOPPED_CONVERSION_SINGLE) ||
                                 (conv_mode == `ADCR_MODE_CHOPPED_CONVERSION_CONT));
         mod_clk_en         <= tick;
         conv_done          <= done;
         conv_busy          <= busy;
      end
   end
endmodule

// file: adcr_regs_chk.sv
/* Port checker for the converter register set.
   Bound to every adcr_regs instance; sees only its ports. */
`timescale 1ns/1ps
module adcr_regs_chk (
   input wire       sys_clk,
   input wire       rst,
   input wire [3:0] reg_addr,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_wdata,
   input wire [7:0] reg_rdata,
   input wire       reg_rvalid,
   input wire [3:0] conv_mode,
   input wire       conv_start,
   input wire       first_stage_enable,
   input wire [2:0] first_stage_gain,
   input wire [1:0] second_stage_gain,
   input wire       trim_dac_enable,
   input wire [4:0] trim_dac_code,
   input wire       offset_apply,
   input wire       mod_clk_en,
   input wire       conv_done,
   input wire       conv_busy
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_read_answer: assert property (reg_rd |=> reg_rvalid)
      else $error("read not answered");
   a_unmapped_zero: assert property (reg_rd && (reg_addr == 4'h0 || reg_addr > 4'h5)
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_clock_unused: assert property (reg_rd && reg_addr == 4'h4
      |=> (reg_rdata & 8'hC8) == 8'h00) else $error("clock unused bits set");
   a_unused_top: assert property (reg_rd && (reg_addr == 4'h3 || reg_addr == 4'h5)
      |=> reg_rdata[7:6] == 2'h0) else $error("top bits set");
   a_amp_follow: assert property (reg_wr && reg_addr == 4'h3 |-> ##2
      {second_stage_gain, first_stage_enable, first_stage_gain} == $past(reg_wdata[5:0], 2))
      else $error("amplifier fields wrong");
   a_trim_follow: assert property (reg_wr && reg_addr == 4'h5 |-> ##2
      {trim_dac_enable, trim_dac_code} == $past(reg_wdata[5:0], 2))
      else $error("trim fields wrong");
   a_offset_chopped_conversion: assert property ((conv_mode == 4'h4 || conv_mode == 4'h5)
      |=> !offset_apply) else $error("offset used in chopped mode");
   a_offset_normal: assert property ((conv_mode == 4'h2 || conv_mode == 4'h3)
      |=> offset_apply) else $error("offset dropped in normal mode");
   a_done_pulse: assert property (conv_done |=> !conv_done)
      else $error("done longer than one cycle");
   a_modclk_pulse: assert property (mod_clk_en |=> !mod_clk_en)
      else $error("modulator clock faster than half");
   a_start_busy: assert property (conv_start && conv_mode == 4'h2 && !conv_busy
      |-> ##2 conv_busy) else $error("start did not raise busy");
endmodule
bind adcr_regs adcr_regs_chk u_chk (.*);

// file: adcr_host_model.sv
/* Host model driving the register port strobes.
   Assumes the strobes are taken at the rising edge of sys_clk. */
`timescale 1ns/1ps
module adcr_host_model (
   input  wire       sys_clk,
   output reg  [3:0] reg_addr,
   output reg        reg_wr,
   output reg        reg_rd,
   output reg  [7:0] reg_wdata,
   input  wire [7:0] reg_rdata,
   input  wire       reg_rvalid
);
   initial begin
      reg_addr = 4'hF;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'hA5;
   end
   // Caller keeps reserved gain and ratio codes out
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge sys_clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
         reg_addr <= ~a;
         reg_wdata <= ~d;
      end
   endtask
   task rd(input [3:0] a, output [7:0] q, output v);
      begin
         @(posedge sys_clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         reg_addr <= ~a;
         #1;
         q = reg_rdata;
         v = reg_rvalid;
      end
   endtask
endmodule

// file: test_adc_result_gain_clock_trim_regs.sv
/* Self-checking bench for the converter register set.
   Uses the host model for register traffic; checker is bound. */
`timescale 1ns/1ps
module test_adc_result_gain_clock_trim_regs;
   reg         sys_clk;
   reg         rst;
   reg  [3:0]  conv_mode;
   reg         conv_start;
   reg  [15:0] filt_data;
   wire [3:0]  reg_addr;
   wire        reg_wr;
   wire        reg_rd;
   wire [7:0]  reg_wdata;
   wire [7:0]  reg_rdata;
   wire        reg_rvalid;
   wire        conv_done;
   wire        conv_busy;
   integer     n_mismatch;
   integer     samples_checked;
   integer     cycles;
   integer     n;
   integer     i;
   reg  [7:0]  q;
   reg         v;
   adcr_regs u_dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .conv_mode(conv_mode), .conv_start(conv_start), .filt_data(filt_data),
      .first_stage_enable(), .first_stage_gain(), .second_stage_gain(), .trim_dac_enable(),
      .trim_dac_code(), .offset_apply(), .mod_clk_en(), .conv_done(conv_done),
      .conv_busy(conv_busy));
   adcr_host_model u_host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   task check(input [15:0] seen, input [15:0] exp);
      begin
         samples_checked = samples_checked + 1;
         if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected at %0t ns: seen %h expected %h", $time, seen, exp);
         end
      end
   endtask
   task rchk(input [3:0] a, input [7:0] exp);
      begin
         u_host.rd(a, q, v);
         check({7'h00, v, q}, {8'h01, exp});
      end
   endtask
   task conclude;
      begin
         $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
         if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   task wait_done;
      begin
         @(posedge sys_clk);
         #1;
         n = n + 1;
         while (conv_done !== 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            #1;
            n = n + 1;
         end
         if (n >= 20000)
            n_mismatch = n_mismatch + 1;
      end
   endtask
   // Runs one conversion; continuous modes measure a full period
   task run(input [3:0] m, input [15:0] d);
      begin
         filt_data <= d;
         repeat (4) @(posedge sys_clk);
         conv_mode <= m;
         conv_start <= ~m[0];
         @(posedge sys_clk);
         conv_start <= 1'b0;
         n = 0;
         wait_done;
         if (m[0]) begin
            n = 0;
            wait_done;
         end
         conv_mode <= 4'h0;
         repeat (4) @(posedge sys_clk);
      end
   endtask
   task tchk(input [3:0] m, input integer e);
      begin
         run(m, 16'h0100);
         check({15'h0000, n >= e - 2 && n <= e + 8}, 16'h0001);
      end
   endtask
   initial begin
      n_mismatch = 0;
      samples_checked = 0;
      cycles = 0;
      rst = 1'b1;
      conv_mode = 4'h0;
      conv_start = 1'b0;
      filt_data = 16'h0000;
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      rchk(4'h3, 8'h00);
      rchk(4'h4, 8'h03);
      rchk(4'h5, 8'h00);
      rchk(4'h7, 8'h00);
      $display("reset values test done");
      u_host.wr(4'h3, 8'hEF);
      u_host.wr(4'h4, 8'hF8);
      u_host.wr(4'h5, 8'hFF);
      u_host.wr(4'h1, 8'h55);
      rchk(4'h3, 8'h2F);
      rchk(4'h4, 8'h30);
      rchk(4'h5, 8'h3F);
      $display("masking test done");
      u_host.wr(4'h3, 8'h08);
      u_host.wr(4'h4, 8'h00);
      u_host.wr(4'h5, 8'h00);
      run(4'h2, 16'h1234);
      rchk(4'h1, 8'h12);
      rchk(4'h2, 8'h34);
      u_host.wr(4'h3, 8'h19);
      run(4'h2, 16'h0123);
      rchk(4'h1, 8'h04);
      rchk(4'h2, 8'h8C);
      run(4'h2, 16'h7000);
      rchk(4'h1, 8'h7F);
      rchk(4'h2, 8'hFF);
      run(4'h2, 16'h9000);
      rchk(4'h1, 8'h80);
      rchk(4'h2, 8'h00);
      $display("result scaling test done");
      u_host.wr(4'h3, 8'h08);
      run(4'h2, 16'h4321);
      rchk(4'h1, 8'h43);
      run(4'h2, 16'h1234);
      rchk(4'h2, 8'h21);
      $display("byte pair test done");
      u_host.wr(4'h5, 8'h23);
      run(4'h2, 16'h1000);
      rchk(4'h1, 8'h10);
      rchk(4'h2, 8'h30);
      u_host.wr(4'h5, 8'h33);
      run(4'h2, 16'h1000);
      rchk(4'h1, 8'h0F);
      rchk(4'h2, 8'hD0);
      u_host.wr(4'h5, 8'h13);
      run(4'h2, 16'h1000);
      rchk(4'h1, 8'h10);
      rchk(4'h2, 8'h00);
      u_host.wr(4'h3, 8'h07);
      run(4'h2, 16'h1000);
      rchk(4'h1, 8'h10);
      rchk(4'h2, 8'h00);
      u_host.wr(4'h3, 8'h0F);
      run(4'h2, 16'h0001);
      rchk(4'h1, 8'h00);
      rchk(4'h2, 8'h80);
      $display("trim and first stage test done");
      for (i = 2; i < 6; i = i + 1) begin
         tchk(i[3:0], 128 * ((i == 2) ? 3 : (i == 3) ? 1 : (i == 4) ? 6 : 3));
      end
      u_host.wr(4'h4, 8'h11);
      tchk(4'h2, 1536);
      u_host.wr(4'h4, 8'h23);
      tchk(4'h2, 12288);
      $display("conversion rate test done");
      conclude;
   end
   always @(posedge sys_clk) begin
      cycles = cycles + 1;
      if (cycles >= 60000) begin
         n_mismatch = n_mismatch + 1;
         conclude;
      end
   end
endmodule
